// ===== gph_pkg.sv
// Purpose: Shared constants for the port data register block
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Printed offsets are register indices; byte address is four times the index

package gph_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [31:0] IDX_THREE_PIN = 32'hFFFF1270;
  localparam logic [31:0] IDX_TWO_PIN = 32'hFFFF1282;
  localparam logic [31:0] IDX_INPUT_ONLY = 32'hFFFF1290;
  localparam logic [31:0] ADDR_THREE_PIN = {IDX_THREE_PIN[29:0], 2'b00};
  localparam logic [31:0] ADDR_TWO_PIN = {IDX_TWO_PIN[29:0], 2'b00};
  localparam logic [31:0] ADDR_INPUT_ONLY = {IDX_INPUT_ONLY[29:0], 2'b00};

  // ****************************************
  // Field layout
  // ****************************************
  localparam int THREE_PIN_COUNT = 3;
  localparam int TWO_PIN_COUNT = 2;
  localparam int INPUT_PIN_COUNT = 8;
  localparam int THREE_PIN_LSB = 13;
  localparam int THREE_PIN_WIDTH = 16;
  localparam int TWO_PIN_LSB = 0;
  localparam int TWO_PIN_WIDTH = 8;
  localparam int INPUT_WIDTH = 8;

  // ****************************************
  // Reset values and fixed read levels
  // ****************************************
  localparam logic [2:0] RESET_THREE_PIN = 3'h0;
  localparam logic [1:0] RESET_TWO_PIN = 2'h0;
  localparam logic UNDEFINED_READ = 1'b0;
  localparam logic ADC_SAMPLE_READ = 1'b1;

endpackage : gph_pkg

// ===== gph_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps

module gph_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic mclk,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // ****************************************
  // Synchroniser stages
  // ****************************************
  always_comb begin
    next_stage1 = stage1;
    next_sync_out = sync_out;
    if (ce) begin
      next_stage1 = async_in;
      next_sync_out = stage1;
    end
  end

  always_ff @(posedge mclk) begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end

endmodule : gph_sync

// ===== gph_pin_cell.sv
// Purpose: Read value and drive decision for one bidirectional pin
// Assumes: Direction and function selection come from logic on mclk
// Notes: Purely combinational
`timescale 1ns/1ps

module gph_pin_cell (
  // Configuration
  input wire logic direction,
  input wire logic func_general,
  // Data
  input wire logic stored,
  input wire logic pin_level,
  output logic read_bit,
  output logic drive_en
);

  // ****************************************
  // Read select and drive enable
  // ****************************************
  always_comb begin
    read_bit = stored;
    drive_en = 1'b0;
    if (direction) begin
      read_bit = stored;
      drive_en = func_general;
    end else if (func_general) begin
      read_bit = pin_level;
    end else begin
      read_bit = gph_pkg::UNDEFINED_READ;
    end
  end

endmodule : gph_pin_cell

// ===== gph_ports.sv
// Purpose: Data registers of a three-pin port, a two-pin port and an input-only port
// Assumes: APB4 slave on mclk, resetn is the external power-on reset
// Notes: Direction, function select and converter sampling come from neighbouring logic
`timescale 1ns/1ps

// Overview of operation
// - Three-pin register is 16 bits; bits 15..13 data, rest read zero.
// - General output pin drives stored bit; read returns stored bit.
// - General input pin reads live level; write only updates storage.
// - Direction 0, non-general function: read undefined, write only stores.
// - Direction 1, non-general function: read stored bit, write does not drive.
// - Bidirectional data clear only on power-on reset, kept otherwise.
// - Two-pin register is 8 bits; bits 1..0 data, rest read zero.
// - Two-pin register at its fixed address, byte access, resets to zero.
// - Input-only register is 8 bits read-only, one bit per pin.
// - Writes to the input-only register are discarded.
// - Input-only reads return current pin levels, not latched values.
// - Pin under converter sampling reads as one.
// - Input-only register has no reset value, reflects pins not under converter sampling.
module gph_ports (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Three-pin port
  input wire logic [2:0] three_pin_in,
  input wire logic [2:0] three_pin_port_direction,
  input wire logic [2:0] three_pin_func_general,
  output logic [2:0] three_pin_out,
  output logic [2:0] three_pin_oe,
  // Two-pin port
  input wire logic [1:0] two_pin_in,
  input wire logic [1:0] two_pin_port_direction,
  input wire logic [1:0] two_pin_func_general,
  output logic [1:0] two_pin_out,
  output logic [1:0] two_pin_oe,
  // Input-only port
  input wire logic [7:0] input_pin_in,
  input wire logic [7:0] analog_input_function
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0] port_three_pin_data_high;
  logic [2:0] next_port_three_pin_data_high;
  logic [1:0] port_two_pin_data;
  logic [1:0] next_port_two_pin_data;
  logic [2:0] next_three_pin_out;
  logic [2:0] next_three_pin_oe;
  logic [1:0] next_two_pin_out;
  logic [1:0] next_two_pin_oe;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [2:0] three_sync;
  logic [1:0] two_sync;
  logic [7:0] input_sync;
  logic [2:0] three_read;
  logic [2:0] three_drive;
  logic [1:0] two_read;
  logic [1:0] two_drive;
  logic [7:0] port_input_only_data;
  logic [15:0] three_word;
  logic [7:0] two_word;
  logic sel_three;
  logic sel_two;
  logic sel_input;
  logic sel_any;
  logic setup_phase;
  logic write_commit;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  gph_sync #(
    .WIDTH(gph_pkg::THREE_PIN_COUNT)
  ) u_sync_three (
    .mclk(mclk),
    .ce(ce),
    .async_in(three_pin_in),
    .sync_out(three_sync)
  );

  gph_sync #(
    .WIDTH(gph_pkg::TWO_PIN_COUNT)
  ) u_sync_two (
    .mclk(mclk),
    .ce(ce),
    .async_in(two_pin_in),
    .sync_out(two_sync)
  );

  gph_sync #(
    .WIDTH(gph_pkg::INPUT_PIN_COUNT)
  ) u_sync_input (
    .mclk(mclk),
    .ce(ce),
    .async_in(input_pin_in),
    .sync_out(input_sync)
  );

  // ****************************************
  // Bidirectional pin cells
  // ****************************************
  for (genvar gi = 0; gi < gph_pkg::THREE_PIN_COUNT; gi++) begin : g_three
    gph_pin_cell u_cell (
      .direction(three_pin_port_direction[gi]),
      .func_general(three_pin_func_general[gi]),
      .stored(port_three_pin_data_high[gi]),
      .pin_level(three_sync[gi]),
      .read_bit(three_read[gi]),
      .drive_en(three_drive[gi])
    );
  end

  for (genvar hi = 0; hi < gph_pkg::TWO_PIN_COUNT; hi++) begin : g_two
    gph_pin_cell u_cell (
      .direction(two_pin_port_direction[hi]),
      .func_general(two_pin_func_general[hi]),
      .stored(port_two_pin_data[hi]),
      .pin_level(two_sync[hi]),
      .read_bit(two_read[hi]),
      .drive_en(two_drive[hi])
    );
  end

  // ****************************************
  // Input-only port view
  // ****************************************
  always_comb begin
    port_input_only_data = input_sync;
    for (int k = 0; k < gph_pkg::INPUT_PIN_COUNT; k++) begin
      if (analog_input_function[k]) begin
        port_input_only_data[k] = gph_pkg::ADC_SAMPLE_READ;
      end
    end
  end

  // ****************************************
  // Read words
  // ****************************************
  always_comb begin
    three_word = '0;
    three_word[gph_pkg::THREE_PIN_LSB +: gph_pkg::THREE_PIN_COUNT] = three_read;
    two_word = '0;
    two_word[gph_pkg::TWO_PIN_LSB +: gph_pkg::TWO_PIN_COUNT] = two_read;
  end

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    sel_three = 1'b0;
    sel_two = 1'b0;
    sel_input = 1'b0;
    if (paddr == gph_pkg::ADDR_THREE_PIN) begin
      sel_three = 1'b1;
    end else if (paddr == gph_pkg::ADDR_TWO_PIN) begin
      sel_two = 1'b1;
    end else if (paddr == gph_pkg::ADDR_INPUT_ONLY) begin
      sel_input = 1'b1;
    end
  end

  assign sel_any = sel_three | sel_two | sel_input;
  assign setup_phase = psel & ~penable & ~pready;
  assign write_commit = psel & penable & pready & pwrite & sel_any;

  // ****************************************
  // APB response
  // ****************************************
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (ce) begin
      next_pready = setup_phase;
      next_pslverr = setup_phase & ~sel_any;
      if (setup_phase) begin
        next_prdata = '0;
        if (!pwrite) begin
          if (sel_three) begin
            next_prdata[gph_pkg::THREE_PIN_WIDTH-1:0] = three_word;
          end else if (sel_two) begin
            next_prdata[gph_pkg::TWO_PIN_WIDTH-1:0] = two_word;
          end else if (sel_input) begin
            next_prdata[gph_pkg::INPUT_WIDTH-1:0] = port_input_only_data;
          end
        end
      end
    end else begin
      next_pready = pready;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // Stored data registers
  // ****************************************
  always_comb begin
    next_port_three_pin_data_high = port_three_pin_data_high;
    next_port_two_pin_data = port_two_pin_data;
    if (ce && write_commit) begin
      if (sel_three && pstrb[1]) begin
        next_port_three_pin_data_high =
          pwdata[gph_pkg::THREE_PIN_LSB +: gph_pkg::THREE_PIN_COUNT];
      end else if (sel_two && pstrb[0]) begin
        next_port_two_pin_data =
          pwdata[gph_pkg::TWO_PIN_LSB +: gph_pkg::TWO_PIN_COUNT];
      end
      // Input-only writes fall through with no effect
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      port_three_pin_data_high <= gph_pkg::RESET_THREE_PIN;
      port_two_pin_data <= gph_pkg::RESET_TWO_PIN;
    end else begin
      port_three_pin_data_high <= next_port_three_pin_data_high;
      port_two_pin_data <= next_port_two_pin_data;
    end
  end

  // ****************************************
  // Pin drive outputs
  // ****************************************
  always_comb begin
    next_three_pin_out = three_pin_out;
    next_three_pin_oe = three_pin_oe;
    next_two_pin_out = two_pin_out;
    next_two_pin_oe = two_pin_oe;
    if (ce) begin
      next_three_pin_out = next_port_three_pin_data_high;
      next_three_pin_oe = three_drive;
      next_two_pin_out = next_port_two_pin_data;
      next_two_pin_oe = two_drive;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      three_pin_out <= '0;
      three_pin_oe <= '0;
      two_pin_out <= '0;
      two_pin_oe <= '0;
    end else begin
      three_pin_out <= next_three_pin_out;
      three_pin_oe <= next_three_pin_oe;
      two_pin_out <= next_two_pin_out;
      two_pin_oe <= next_two_pin_oe;
    end
  end

endmodule : gph_ports

// ===== gph_ports_sva.sv
// Purpose: Concurrent checks on the port data register block
// Assumes: ce low only between transfers
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
module gph_ports_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins
  input wire logic [2:0] three_pin_port_direction,
  input wire logic [2:0] three_pin_func_general,
  input wire logic [2:0] three_pin_out,
  input wire logic [2:0] three_pin_oe,
  input wire logic [1:0] two_pin_out,
  input wire logic [7:0] analog_input_function
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic wr;
  logic rd;
  assign wr = psel && penable && pready && pwrite;
  assign rd = pready && !pwrite;
  AST_READY_ONE: assert property (psel && !penable && !pready && ce |=> pready)
    else $error("no answer one cycle after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_OE: assert property ($past(resetn) && $past(ce) |-> three_pin_oe ==
    ($past(three_pin_port_direction) & $past(three_pin_func_general)))
    else $error("output enable wrong");
  AST_THREE_WR: assert property (wr && paddr == gph_pkg::ADDR_THREE_PIN && pstrb[1]
    |=> three_pin_out == $past(pwdata[15:13]))
    else $error("three pin drive wrong");
  AST_TWO_WR: assert property (wr && paddr == gph_pkg::ADDR_TWO_PIN && pstrb[0]
    |=> two_pin_out == $past(pwdata[1:0]))
    else $error("two pin drive wrong");
  AST_THREE_RESV: assert property (rd && paddr == gph_pkg::ADDR_THREE_PIN
    |-> prdata[12:0] == 13'h0 && prdata[31:16] == 16'h0)
    else $error("three pin reserved bits set");
  AST_TWO_RESV: assert property (rd && paddr == gph_pkg::ADDR_TWO_PIN
    |-> prdata[31:2] == 30'h0)
    else $error("two pin reserved bits set");
  AST_ADC: assert property (rd && paddr == gph_pkg::ADDR_INPUT_ONLY && $past(ce)
    |-> (prdata[7:0] | $past(analog_input_function)) == prdata[7:0])
    else $error("sampled pin not read as one");
  AST_RESET: assert property ($rose(resetn) |-> three_pin_out == 3'h0
    && two_pin_out == 2'h0 && three_pin_oe == 3'h0 && !pready)
    else $error("state not cleared by reset");
endmodule : gph_ports_sva

// ===== gph_pins_model.sv
// Purpose: Board side of the bidirectional pins
// Assumes: Board level seen where the block does not drive
// Notes: Behavioural
`timescale 1ns/1ps
module gph_pins_model (
  // Block drive
  input wire logic [2:0] three_pin_out,
  input wire logic [2:0] three_pin_oe,
  input wire logic [1:0] two_pin_out,
  input wire logic [1:0] two_pin_oe,
  // Board levels
  input wire logic [2:0] board_three,
  input wire logic [1:0] board_two,
  // Pin levels
  output logic [2:0] three_pin_in,
  output logic [1:0] two_pin_in
);
  assign three_pin_in = (three_pin_oe & three_pin_out) | (~three_pin_oe & board_three);
  assign two_pin_in = (two_pin_oe & two_pin_out) | (~two_pin_oe & board_two);
endmodule : gph_pins_model

// ===== tb_gph_ports.sv
// Purpose: Register level test of the port data block
// Assumes: ce low only between transfers
// Notes: Pins settle after two synchroniser edges
`timescale 1ns/1ps
module tb_gph_ports;
  logic mclk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, e;
  logic [2:0] tin, dir3 = 3'h7, fn3 = 3'h7, tout, toe, b3 = 3'h2;
  logic [1:0] win, dir2 = 2'h3, fn2 = 2'h3, wout, woe, b2 = 2'h1;
  logic [7:0] ipin = 8'hA5, adc = 8'h00;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  localparam logic [31:0] A3 = gph_pkg::ADDR_THREE_PIN;
  localparam logic [31:0] A2 = gph_pkg::ADDR_TWO_PIN;
  localparam logic [31:0] AI = gph_pkg::ADDR_INPUT_ONLY;
  always #2.5 mclk = ~mclk;
  gph_ports gph_ports_inst (.mclk(mclk), .resetn(resetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .three_pin_in(tin),
    .three_pin_port_direction(dir3), .three_pin_func_general(fn3), .three_pin_out(tout),
    .three_pin_oe(toe), .two_pin_in(win), .two_pin_port_direction(dir2),
    .two_pin_func_general(fn2), .two_pin_out(wout), .two_pin_oe(woe),
    .input_pin_in(ipin), .analog_input_function(adc));
  gph_pins_model gph_pins_model_inst (.three_pin_out(tout), .three_pin_oe(toe),
    .two_pin_out(wout), .two_pin_oe(woe), .board_three(b3), .board_two(b2),
    .three_pin_in(tin), .two_pin_in(win));
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task rd(input logic [31:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task settle;
    repeat (4) @(posedge mclk);
  endtask : settle
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1;
    rd(A3, 32'h0);
    rd(A2, 32'h0);
    $display("reset values done");
    apb(1, A3, 32'hFFFFA000);
    rd(A3, 32'h0000A000);
    chk({29'h0, tout}, 32'h5);
    dir3 <= 3'h0; settle;
    rd(A3, 32'h00004000);
    apb(1, A3, 32'h00006000);
    chk({29'h0, toe}, 32'h0);
    fn3 <= 3'h0; settle;
    rd(A3, 32'h0);
    dir3 <= 3'h7; settle;
    rd(A3, 32'h00006000);
    chk({29'h0, toe}, 32'h0);
    fn3 <= 3'h7; settle;
    chk({29'h0, toe, tout}, 32'h3B);
    $display("three pin done");
    apb(1, A2, 32'hFFFFFFFE);
    rd(A2, 32'h2);
    chk({28'h0, woe, wout}, 32'hE);
    pstrb <= 4'hE;
    apb(1, A2, 32'h1);
    pstrb <= 4'hF;
    rd(A2, 32'h2);
    dir2 <= 2'h0; settle;
    rd(A2, 32'h1);
    chk({30'h0, woe}, 32'h0);
    apb(1, 32'h00000010, 32'h1);
    chk({31'h0, e}, 32'h1);
    $display("two pin done");
    rd(AI, 32'hA5);
    apb(1, AI, 32'h0);
    rd(AI, 32'hA5);
    adc <= 8'h0F;
    rd(AI, 32'hAF);
    adc <= 8'h00; ipin <= 8'h3C; settle;
    rd(AI, 32'h3C);
    $display("input port done");
    ce <= 0;
    dir3 <= 3'h0;
    repeat (3) @(posedge mclk);
    chk({29'h0, toe}, 32'h7);
    ce <= 1;
    settle;
    chk({29'h0, toe}, 32'h0);
    dir3 <= 3'h7;
    settle;
    chk({29'h0, toe}, 32'h7);
    $display("clock enable done");
    resetn <= 0;
    repeat (2) @(posedge mclk);
    resetn <= 1;
    rd(A3, 32'h0);
    rd(AI, 32'h3C);
    $display("second reset done");
    test_done;
  end
endmodule : tb_gph_ports
bind gph_ports gph_ports_sva gph_ports_sva_inst (.mclk, .resetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .three_pin_port_direction,
  .three_pin_func_general, .three_pin_out, .three_pin_oe, .two_pin_out,
  .analog_input_function);
